// File: rtl/lpm_pkg.sv
// Shared types and constants for the low-power mode controller
`default_nettype none
package lpm_pkg;
  // Peripheral clock groups, one bit each:
  // 0 adc, 1 cmp, 2 lptmr, 3 rtc, 4 pin_irq, 5 osc, 6 lpit, 7 serial, 8 dma, 9 ftm
  localparam int NUM_PERIPH = 10;
  localparam int NUM_WAKE = 8;
  localparam logic [NUM_PERIPH-1:0] STOP_KEEP_MASK = 10'h01f;
  localparam logic [NUM_PERIPH-1:0] VERY_LOW_POWER_STOP_KEEP_MASK = 10'h1ef;
  localparam logic [NUM_PERIPH-1:0] ALL_PERIPH_MASK = 10'h3ff;

  // Clock divider outputs
  localparam int DIV_W = 4;
  localparam int NUM_CLK = 3;
  localparam int CLK_MASTER = 0;
  localparam int CLK_SLAVE = 1;
  localparam int CLK_FLASH = 2;
  localparam logic [DIV_W-1:0] DIV_CNT_RESET = 4'h0;

  // Flash configuration byte that carries the security field
  localparam logic [31:0] FCF_SEC_ADDR = 32'h0000_040e;
  localparam int SEC_FIELD_LSB = 0;
  localparam int SEC_FIELD_W = 2;
  localparam logic [SEC_FIELD_W-1:0] SEC_UNSECURE_CODE = 2'h2;

  typedef enum logic [1:0] {
    RUN_NORMAL,
    RUN_VLP,
    RUN_HS
  } lpm_run_type;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_VERY_LOW_POWER_RUN,
    ST_HIGH_SPEED_RUN,
    ST_WAIT,
    ST_VERY_LOW_POWER_WAIT,
    ST_STOP,
    ST_VERY_LOW_POWER_STOP,
    ST_WAKE
  } lpm_state_type;

  typedef struct packed {
    logic sleep_until_interrupt_instr;
    logic sleep_until_event_instr;
    logic deep;
    lpm_run_type run_req;
  } lpm_core_req_type;

  typedef struct packed {
    logic core_active;
    logic core_sleep;
    logic nested_vector_irq_ctl_on;
    logic async_wake_controller_on;
    logic lvd_on;
    logic reduced_freq;
    logic sram_retain;
    logic reg_retain;
  } lpm_pwr_stat_type;

  localparam lpm_pwr_stat_type PWR_RUN = '{core_active: 1'h1, core_sleep: 1'h0,
    nested_vector_irq_ctl_on: 1'h1, async_wake_controller_on: 1'h0, lvd_on: 1'h1, reduced_freq: 1'h0,
    sram_retain: 1'h1, reg_retain: 1'h1};
endpackage : lpm_pkg
`default_nettype wire

// File: rtl/lpm_sync.sv
// Two-flop synchroniser for asynchronous wake inputs
`default_nettype none
module lpm_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d_async,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d_async;
      q <= meta;
    end
  end
endmodule : lpm_sync
`default_nettype wire

// File: rtl/lpm_clk_div.sv
// Programmable clock divider producing a one-cycle enable tick
`default_nettype none
module lpm_clk_div
  import lpm_pkg::*;
#(
  parameter int W = DIV_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] div,
  output logic tick
);
  logic [W-1:0] cnt;

  // Tick once every div+1 cycles; div of zero gives a tick each cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt <= W'(DIV_CNT_RESET);
      tick <= 1'h0;
    end else if (cnt >= div) begin
      cnt <= W'(DIV_CNT_RESET);
      tick <= 1'h1;
    end else begin
      cnt <= cnt + W'(1);
      tick <= 1'h0;
    end
  end
endmodule : lpm_clk_div
`default_nettype wire

// File: rtl/lpm_ctrl.sv
// Power-mode controller: mode sequencing, clock gating, security and flash gating
// Behaviour
// - Sleep instruction enters wait-class or stop-class mode per deep-sleep setting.
// - Run and very-low-power run keep core active; clock speed, voltage monitor and flash access differ.
// - Wait modes halt core; enabled peripherals keep their clocks.
// - Stop modes disable core; stop gates osc, lpit, serial, dma and ftm, very-low-power stop only pin_irq and ftm; retention per mode.
// - Wake from wait modes comes through the nested interrupt controller.
// - Wake from stop modes comes through the async wake controller.
// - Very-low-power run reduces clocks and turns the voltage monitor off.
// - Very-low-power wait reduces clocks, monitor off, core sleeping.
// - Stop gates most clocks, retains registers and SRAM, monitor stays on.
// - Stop keeps converter, comparator, timer, clock, pin interrupts; interrupt ctl off.
// - Very-low-power stop retains SRAM, keeps listed modules; monitor, interrupt ctl off.
// - Security from flash config byte blocks debug memory access.
// - Debugger mass-erase request on secured part runs erase-all, then unsecures.
// - High-speed run and very-low-power modes refuse EEPROM writes and flash commands.
// - Divide clock for masters, slaves, flash; per-module clock gates.
// - Stop-class wake requests clock restart; interrupt ctl then services it.
`default_nettype none
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter logic [SEC_FIELD_W-1:0] UNSECURE_CODE = SEC_UNSECURE_CODE
) (
  input wire logic mclk,
  input wire logic rst,
  input wire lpm_pkg::lpm_core_req_type core_req,
  input wire logic irq_pending,
  input wire logic event_in,
  input wire logic [lpm_pkg::NUM_WAKE-1:0] wake_async,
  input wire logic clk_stable,
  input wire logic [lpm_pkg::NUM_CLK-1:0][lpm_pkg::DIV_W-1:0] div_cfg,
  input wire logic [lpm_pkg::NUM_PERIPH-1:0] module_gate,
  input wire logic cfg_rd_valid,
  input wire logic [7:0] cfg_rd_data,
  input wire logic dbg_mem_req,
  input wire logic dbg_mass_erase_wr,
  input wire logic erase_all_done,
  input wire logic flash_cmd_req,
  input wire logic eeprom_wr_req,
  output lpm_pkg::lpm_state_type mode,
  output lpm_pkg::lpm_pwr_stat_type pwr_stat,
  output logic [lpm_pkg::NUM_PERIPH-1:0] periph_clk_en,
  output logic [lpm_pkg::NUM_CLK-1:0] clk_en,
  output logic clk_restart_req,
  output logic cfg_rd_req,
  output logic [31:0] cfg_rd_addr,
  output logic secured,
  output logic dbg_mem_grant,
  output logic dbg_mem_deny,
  output logic mass_erase_busy,
  output logic erase_all_launch,
  output logic flash_cmd_grant,
  output logic flash_cmd_reject,
  output logic eeprom_wr_grant,
  output logic eeprom_wr_refuse
);
  import lpm_pkg::*;
  lpm_state_type next_mode;
  lpm_state_type saved_mode;
  logic [NUM_WAKE-1:0] wake_sync;
  logic [NUM_CLK-1:0] div_tick;
  logic wake_any;
  logic wfe_armed;
  logic from_stop;
  logic erase_launched;
  logic flash_ok;
  logic sleep_req;
  function automatic logic is_stop_class(input lpm_state_type s);
    return (s == ST_STOP) || (s == ST_VERY_LOW_POWER_STOP);
  endfunction : is_stop_class
  function automatic logic is_run_class(input lpm_state_type s);
    return (s == ST_RUN) || (s == ST_VERY_LOW_POWER_RUN) || (s == ST_HIGH_SPEED_RUN);
  endfunction : is_run_class
  function automatic lpm_state_type run_of(input lpm_run_type r);
    unique case (r)
      RUN_NORMAL: return ST_RUN;
      RUN_VLP: return ST_VERY_LOW_POWER_RUN;
      RUN_HS: return ST_HIGH_SPEED_RUN;
      default: return ST_RUN;
    endcase
  endfunction : run_of
  function automatic lpm_pwr_stat_type pwr_of(input lpm_state_type s);
    lpm_pwr_stat_type p;
    logic vlp;
    vlp = (s == ST_VERY_LOW_POWER_RUN) || (s == ST_VERY_LOW_POWER_WAIT) || (s == ST_VERY_LOW_POWER_STOP);
    p = PWR_RUN;
    p.core_active = is_run_class(s);
    p.core_sleep = !is_run_class(s);
    p.nested_vector_irq_ctl_on = !is_stop_class(s);
    p.async_wake_controller_on = is_stop_class(s);
    p.lvd_on = !vlp;
    p.reduced_freq = vlp;
    // Only SRAM survives very-low-power stop
    p.reg_retain = (s != ST_VERY_LOW_POWER_STOP);
    return p;
  endfunction : pwr_of
  function automatic logic [NUM_PERIPH-1:0] keep_of(input lpm_state_type s);
    unique case (s)
      ST_STOP: return STOP_KEEP_MASK;
      ST_VERY_LOW_POWER_STOP: return VERY_LOW_POWER_STOP_KEEP_MASK;
      default: return ALL_PERIPH_MASK;
    endcase
  endfunction : keep_of
  // Wake pins are asynchronous to mclk
  lpm_sync #(
    .W(NUM_WAKE)
  ) u_wake_sync (
    .mclk(mclk),
    .rst(rst),
    .d_async(wake_async),
    .q(wake_sync)
  );
  assign wake_any = |wake_sync;
  assign sleep_req = core_req.sleep_until_interrupt_instr || core_req.sleep_until_event_instr;
  assign flash_ok = !((mode == ST_HIGH_SPEED_RUN) || (mode == ST_VERY_LOW_POWER_RUN) ||
                      (mode == ST_VERY_LOW_POWER_WAIT) || (mode == ST_VERY_LOW_POWER_STOP));
  always_comb begin
    next_mode = mode;
    unique case (mode)
      ST_RUN, ST_VERY_LOW_POWER_RUN, ST_HIGH_SPEED_RUN: begin
        if (sleep_req) begin
          if (core_req.deep) begin
            next_mode = (mode == ST_VERY_LOW_POWER_RUN) ? ST_VERY_LOW_POWER_STOP : ST_STOP;
          end else begin
            next_mode = (mode == ST_VERY_LOW_POWER_RUN) ? ST_VERY_LOW_POWER_WAIT : ST_WAIT;
          end
        end else begin
          next_mode = run_of(core_req.run_req);
        end
      end
      ST_WAIT, ST_VERY_LOW_POWER_WAIT: begin
        if (irq_pending || (wfe_armed && event_in)) begin
          next_mode = ST_WAKE;
        end
      end
      ST_STOP, ST_VERY_LOW_POWER_STOP: begin
        if (wake_any) begin
          next_mode = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (clk_stable) begin
          next_mode = saved_mode;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode <= ST_RUN;
    end else begin
      mode <= next_mode;
    end
  end
  // Remember the run mode and the kind of sleep for the way back
  always_ff @(posedge mclk) begin
    if (rst) begin
      saved_mode <= ST_RUN;
      wfe_armed <= 1'h0;
      from_stop <= 1'h0;
    end else if (is_run_class(mode) && sleep_req) begin
      saved_mode <= mode;
      wfe_armed <= core_req.sleep_until_event_instr && !core_req.sleep_until_interrupt_instr;
      from_stop <= core_req.deep;
    end
  end
  // Outputs decoded from the next mode so they line up with the mode flop
  always_ff @(posedge mclk) begin
    if (rst) begin
      pwr_stat <= PWR_RUN;
      periph_clk_en <= '0;
    end else begin
      pwr_stat <= pwr_of(next_mode);
      periph_clk_en <= module_gate & keep_of(next_mode);
    end
  end
  // Held until the clock generator reports stable clocks
  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_restart_req <= 1'h0;
    end else begin
      clk_restart_req <= (is_stop_class(mode) && wake_any) ||
                         (mode == ST_WAKE && from_stop && !clk_stable);
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CLK; gi++) begin : g_div
      lpm_clk_div #(
        .W(DIV_W)
      ) u_div (
        .mclk(mclk),
        .rst(rst),
        .div(div_cfg[gi]),
        .tick(div_tick[gi])
      );
    end
  endgenerate
  // Master clock follows the core; slave and flash clocks stop in deep sleep
  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_en <= '0;
    end else begin
      clk_en[CLK_MASTER] <= div_tick[CLK_MASTER] && is_run_class(next_mode);
      clk_en[CLK_SLAVE] <= div_tick[CLK_SLAVE] && !is_stop_class(next_mode);
      clk_en[CLK_FLASH] <= div_tick[CLK_FLASH] && !is_stop_class(next_mode);
    end
  end
  // Part counts as secured until the configuration byte has been read
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_rd_req <= 1'h1;
      cfg_rd_addr <= FCF_SEC_ADDR;
      secured <= 1'h1;
    end else if (cfg_rd_req && cfg_rd_valid) begin
      cfg_rd_req <= 1'h0;
      secured <= cfg_rd_data[SEC_FIELD_LSB +: SEC_FIELD_W] != UNSECURE_CODE;
    end else if (mass_erase_busy && erase_all_done) begin
      secured <= 1'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dbg_mem_grant <= 1'h0;
      dbg_mem_deny <= 1'h0;
    end else begin
      dbg_mem_grant <= dbg_mem_req && !secured;
      dbg_mem_deny <= dbg_mem_req && secured;
    end
  end
  // A new mailbox write beats a completion in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      mass_erase_busy <= 1'h0;
    end else if (dbg_mass_erase_wr && secured) begin
      mass_erase_busy <= 1'h1;
    end else if (erase_all_done) begin
      mass_erase_busy <= 1'h0;
    end
  end
  // Launch waits for a mode in which flash commands are allowed
  always_ff @(posedge mclk) begin
    if (rst) begin
      erase_all_launch <= 1'h0;
      erase_launched <= 1'h0;
    end else begin
      erase_all_launch <= mass_erase_busy && !erase_launched && flash_ok;
      erase_launched <= mass_erase_busy && (erase_launched || flash_ok);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      flash_cmd_grant <= 1'h0;
      flash_cmd_reject <= 1'h0;
      eeprom_wr_grant <= 1'h0;
      eeprom_wr_refuse <= 1'h0;
    end else begin
      flash_cmd_grant <= flash_cmd_req && flash_ok;
      flash_cmd_reject <= flash_cmd_req && !flash_ok;
      eeprom_wr_grant <= eeprom_wr_req && flash_ok;
      eeprom_wr_refuse <= eeprom_wr_req && !flash_ok;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_sleep_entry;
    is_run_class(mode) && sleep_req;
  endsequence
  sequence s_stop_wake;
    is_stop_class(mode) && wake_any;
  endsequence
  property p_wait_entry;
    s_sleep_entry ##0 !core_req.deep |=> (mode == ST_WAIT || mode == ST_VERY_LOW_POWER_WAIT);
  endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("no wait entry");
  property p_stop_entry;
    s_sleep_entry ##0 core_req.deep |=> is_stop_class(mode) && !pwr_stat.core_active;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("no stop entry");
  property p_run_active;
    is_run_class(mode) |-> pwr_stat.core_active && !pwr_stat.core_sleep;
  endproperty
  a_run_active: assert property (p_run_active) else $error("core idle in run");
  property p_wait_periph;
    (mode == ST_WAIT) ##1 (mode == ST_WAIT) |-> periph_clk_en == $past(module_gate);
  endproperty
  a_wait_periph: assert property (p_wait_periph) else $error("wait gated clock");
  property p_wait_wake;
    (mode == ST_WAIT || mode == ST_VERY_LOW_POWER_WAIT) && irq_pending |=> mode == ST_WAKE;
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("irq wake missed");
  property p_stop_wake;
    s_stop_wake |=> mode == ST_WAKE && clk_restart_req;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake missed");
  property p_vlp_power;
    (mode == ST_VERY_LOW_POWER_RUN || mode == ST_VERY_LOW_POWER_WAIT) |-> pwr_stat.reduced_freq && !pwr_stat.lvd_on;
  endproperty
  a_vlp_power: assert property (p_vlp_power) else $error("vlp power wrong");
  property p_stop_state;
    mode == ST_STOP |-> pwr_stat.lvd_on && pwr_stat.reg_retain && !pwr_stat.nested_vector_irq_ctl_on &&
      (periph_clk_en & ~STOP_KEEP_MASK) == '0;
  endproperty
  a_stop_state: assert property (p_stop_state) else $error("stop state wrong");
  property p_very_low_power_stop_state;
    mode == ST_VERY_LOW_POWER_STOP |-> pwr_stat.sram_retain && !pwr_stat.lvd_on && !pwr_stat.nested_vector_irq_ctl_on;
  endproperty
  a_very_low_power_stop_state: assert property (p_very_low_power_stop_state) else $error("very_low_power_stop state wrong");
  property p_dbg_block;
    secured && dbg_mem_req |=> dbg_mem_deny && !dbg_mem_grant;
  endproperty
  a_dbg_block: assert property (p_dbg_block) else $error("debug not blocked");
  property p_erase_unsec;
    mass_erase_busy && erase_all_done && !cfg_rd_req |=> !secured;
  endproperty
  a_erase_unsec: assert property (p_erase_unsec) else $error("still secured");
  property p_flash_block;
    flash_cmd_req && !flash_ok |=> flash_cmd_reject && !flash_cmd_grant;
  endproperty
  a_flash_block: assert property (p_flash_block) else $error("flash not blocked");
  property p_wake_hold;
    mode == ST_WAKE && !clk_stable |=> mode == ST_WAKE && !pwr_stat.core_active;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("core early");
  property p_wake_return;
    mode == ST_WAKE && clk_stable |=> mode == $past(saved_mode) && pwr_stat.core_active;
  endproperty
  a_wake_return: assert property (p_wake_return) else $error("bad return");
endmodule : lpm_ctrl
`default_nettype wire

// File: dv/lpm_far_model.sv
// Far-side model: clock generator, configuration memory and flash engine
`default_nettype none
module lpm_far_model
  import lpm_pkg::*;
#(
  parameter int STABLE_DLY = 5,
  parameter int ERASE_DLY = 9,
  parameter logic [7:0] CFG_BYTE = 8'h00
) (
  input wire logic mclk,
  input wire logic rst,
  input wire lpm_pkg::lpm_state_type mode,
  input wire logic clk_restart_req,
  input wire logic cfg_rd_req,
  input wire logic erase_all_launch,
  output logic clk_stable,
  output logic cfg_rd_valid,
  output logic [7:0] cfg_rd_data,
  output logic erase_all_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int stab_cnt;
  int erase_cnt;
  logic next_valid;

  // Clocks halt in deep sleep and settle only while a restart is requested
  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_stable <= 1'b1;
      stab_cnt <= 0;
    end else if (mode == ST_STOP || mode == ST_VERY_LOW_POWER_STOP) begin
      clk_stable <= 1'b0;
      stab_cnt <= 0;
    end else if (clk_restart_req && !clk_stable) begin
      stab_cnt <= stab_cnt + 1;
      clk_stable <= (stab_cnt + 1 >= STABLE_DLY);
    end
  end

  // Data line shows the inverse outside the answer cycle
  assign next_valid = cfg_rd_req && !cfg_rd_valid;
  always_ff @(posedge mclk) begin
    cfg_rd_valid <= !rst && next_valid;
    cfg_rd_data <= next_valid ? CFG_BYTE : ~CFG_BYTE;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      erase_cnt <= 0;
    end else if (erase_all_launch) begin
      erase_cnt <= ERASE_DLY;
    end else if (erase_cnt > 0) begin
      erase_cnt <= erase_cnt - 1;
    end
    erase_all_done <= !rst && erase_cnt == 1;
  end
endmodule : lpm_far_model
`default_nettype wire

// File: dv/lpm_ctrl_tb.sv
// Self-checking testbench for the power-mode controller
`default_nettype none
module lpm_ctrl_tb
  import lpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  lpm_core_req_type core_req = '0;
  logic irq_pending = 1'b0;
  logic event_in = 1'b0;
  logic [NUM_WAKE-1:0] wake_async = '0;
  logic clk_stable;
  logic [NUM_CLK-1:0][DIV_W-1:0] div_cfg = {4'h3, 4'h2, 4'h1};
  logic [NUM_PERIPH-1:0] module_gate = 10'h2a5;
  logic cfg_rd_valid;
  logic [7:0] cfg_rd_data;
  logic dbg_mem_req = 1'b0;
  logic dbg_mass_erase_wr = 1'b0;
  logic erase_all_done;
  logic flash_cmd_req = 1'b0;
  logic eeprom_wr_req = 1'b0;
  lpm_state_type mode;
  lpm_pwr_stat_type pwr_stat;
  logic [NUM_PERIPH-1:0] periph_clk_en;
  logic [NUM_CLK-1:0] clk_en;
  logic clk_restart_req, cfg_rd_req, secured, dbg_mem_grant, dbg_mem_deny;
  logic mass_erase_busy, erase_all_launch, flash_cmd_grant, flash_cmd_reject;
  logic eeprom_wr_grant, eeprom_wr_refuse;
  logic [31:0] cfg_rd_addr;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int tk [NUM_CLK];

  lpm_ctrl lpm_ctrl_inst (.mclk, .rst, .core_req, .irq_pending, .event_in, .wake_async,
    .clk_stable, .div_cfg, .module_gate, .cfg_rd_valid, .cfg_rd_data, .dbg_mem_req,
    .dbg_mass_erase_wr, .erase_all_done, .flash_cmd_req, .eeprom_wr_req, .mode, .pwr_stat,
    .periph_clk_en, .clk_en, .clk_restart_req, .cfg_rd_req, .cfg_rd_addr, .secured,
    .dbg_mem_grant, .dbg_mem_deny, .mass_erase_busy, .erase_all_launch, .flash_cmd_grant,
    .flash_cmd_reject, .eeprom_wr_grant, .eeprom_wr_refuse);

  lpm_far_model lpm_far_model_inst (.mclk, .rst, .mode, .clk_restart_req, .cfg_rd_req,
    .erase_all_launch, .clk_stable, .cfg_rd_valid, .cfg_rd_data, .erase_all_done);

  always #4 mclk = ~mclk;

  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // Hang guard, well above the roughly 150 cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      final_report();
    end
  end

  task automatic step();
    @(posedge mclk);
    #1;
  endtask : step

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wait_mode(lpm_state_type m);
    for (int i = 0; i < 60 && mode !== m; i++) begin
      step();
    end
    check("mode", mode, m);
  endtask : wait_mode

  task automatic sleep(logic deep_sel, logic use_wfe);
    core_req.deep = deep_sel;
    core_req.sleep_until_interrupt_instr = !use_wfe;
    core_req.sleep_until_event_instr = use_wfe;
    step();
    core_req.sleep_until_interrupt_instr = 1'b0;
    core_req.sleep_until_event_instr = 1'b0;
  endtask : sleep

  task automatic flash_try(logic ok);
    flash_cmd_req = 1'b1;
    eeprom_wr_req = 1'b1;
    step();
    flash_cmd_req = 1'b0;
    eeprom_wr_req = 1'b0;
    check("flash_cmd_grant", flash_cmd_grant, ok);
    check("flash_cmd_reject", flash_cmd_reject, !ok);
    check("eeprom_wr_grant", eeprom_wr_grant, ok);
    check("eeprom_wr_refuse", eeprom_wr_refuse, !ok);
  endtask : flash_try

  task automatic count_clk(int n);
    tk = '{default: 0};
    repeat (n) begin
      step();
      for (int k = 0; k < NUM_CLK; k++) begin
        tk[k] += int'(clk_en[k]);
      end
    end
  endtask : count_clk

  task automatic t_reset();
    check("mode", mode, ST_RUN);
    check("pwr_stat", pwr_stat, PWR_RUN);
    check("periph_clk_en", periph_clk_en, 10'h000);
    check("cfg_rd_addr", cfg_rd_addr, FCF_SEC_ADDR);
    check("cfg_rd_req", cfg_rd_req, 1'b1);
    check("secured", secured, 1'b1);
  endtask : t_reset

  task automatic t_security();
    for (int i = 0; i < 20 && cfg_rd_req !== 1'b0; i++) begin
      step();
    end
    check("cfg_rd_req", cfg_rd_req, 1'b0);
    check("secured", secured, 1'b1);
    dbg_mem_req = 1'b1;
    step();
    dbg_mem_req = 1'b0;
    check("dbg_mem_deny", dbg_mem_deny, 1'b1);
    check("dbg_mem_grant", dbg_mem_grant, 1'b0);
    dbg_mass_erase_wr = 1'b1;
    step();
    dbg_mass_erase_wr = 1'b0;
    check("mass_erase_busy", mass_erase_busy, 1'b1);
    step();
    check("erase_all_launch", erase_all_launch, 1'b1);
    for (int i = 0; i < 40 && secured !== 1'b0; i++) begin
      step();
    end
    check("secured", secured, 1'b0);
    check("mass_erase_busy", mass_erase_busy, 1'b0);
    dbg_mem_req = 1'b1;
    step();
    dbg_mem_req = 1'b0;
    check("dbg_mem_grant", dbg_mem_grant, 1'b1);
  endtask : t_security

  task automatic t_run_modes();
    core_req.run_req = RUN_VLP;
    wait_mode(ST_VERY_LOW_POWER_RUN);
    check("core_active", pwr_stat.core_active, 1'b1);
    check("reduced_freq", pwr_stat.reduced_freq, 1'b1);
    check("lvd_on", pwr_stat.lvd_on, 1'b0);
    flash_try(1'b0);
    core_req.run_req = RUN_HS;
    wait_mode(ST_HIGH_SPEED_RUN);
    flash_try(1'b0);
    sleep(1'b0, 1'b0);
    check("mode", mode, ST_WAIT);
    irq_pending = 1'b1;
    wait_mode(ST_HIGH_SPEED_RUN);
    irq_pending = 1'b0;
    core_req.run_req = RUN_NORMAL;
    wait_mode(ST_RUN);
    check("pwr_stat", pwr_stat, PWR_RUN);
    flash_try(1'b1);
    check("periph_clk_en", periph_clk_en, module_gate);
    count_clk(48);
    check("clk_master", tk[CLK_MASTER], 24);
    check("clk_slave", tk[CLK_SLAVE], 16);
    check("clk_flash", tk[CLK_FLASH], 12);
  endtask : t_run_modes

  task automatic t_wait();
    sleep(1'b0, 1'b0);
    check("mode", mode, ST_WAIT);
    check("core_sleep", pwr_stat.core_sleep, 1'b1);
    check("core_active", pwr_stat.core_active, 1'b0);
    check("periph_clk_en", periph_clk_en, module_gate);
    event_in = 1'b1;
    count_clk(12);
    event_in = 1'b0;
    check("mode", mode, ST_WAIT);
    check("clk_master", tk[CLK_MASTER], 0);
    check("clk_slave", tk[CLK_SLAVE], 4);
    check("clk_flash", tk[CLK_FLASH], 3);
    irq_pending = 1'b1;
    wait_mode(ST_RUN);
    irq_pending = 1'b0;
    core_req.run_req = RUN_VLP;
    wait_mode(ST_VERY_LOW_POWER_RUN);
    sleep(1'b0, 1'b1);
    check("mode", mode, ST_VERY_LOW_POWER_WAIT);
    check("lvd_on", pwr_stat.lvd_on, 1'b0);
    check("reduced_freq", pwr_stat.reduced_freq, 1'b1);
    check("core_sleep", pwr_stat.core_sleep, 1'b1);
    flash_try(1'b0);
    event_in = 1'b1;
    wait_mode(ST_VERY_LOW_POWER_RUN);
    event_in = 1'b0;
    core_req.run_req = RUN_NORMAL;
    wait_mode(ST_RUN);
  endtask : t_wait

  task automatic t_stop();
    module_gate = 10'h3ff;
    sleep(1'b1, 1'b0);
    check("mode", mode, ST_STOP);
    check("core_active", pwr_stat.core_active, 1'b0);
    check("nested_vector_irq_ctl_on", pwr_stat.nested_vector_irq_ctl_on, 1'b0);
    check("async_wake_controller_on", pwr_stat.async_wake_controller_on, 1'b1);
    check("lvd_on", pwr_stat.lvd_on, 1'b1);
    check("retain", {pwr_stat.sram_retain, pwr_stat.reg_retain}, 2'h3);
    check("periph_clk_en", periph_clk_en, STOP_KEEP_MASK);
    flash_try(1'b1);
    irq_pending = 1'b1;
    count_clk(12);
    check("clk_en_stop", tk[CLK_MASTER] + tk[CLK_SLAVE] + tk[CLK_FLASH], 0);
    check("mode", mode, ST_STOP);
    irq_pending = 1'b0;
    wake_async = 8'h08;
    wait_mode(ST_WAKE);
    check("clk_restart_req", clk_restart_req, 1'b1);
    wake_async = 8'h00;
    wait_mode(ST_RUN);
    check("clk_restart_req", clk_restart_req, 1'b0);
    core_req.run_req = RUN_VLP;
    wait_mode(ST_VERY_LOW_POWER_RUN);
    sleep(1'b1, 1'b1);
    check("mode", mode, ST_VERY_LOW_POWER_STOP);
    check("lvd_on", pwr_stat.lvd_on, 1'b0);
    check("nested_vector_irq_ctl_on", pwr_stat.nested_vector_irq_ctl_on, 1'b0);
    check("sram_retain", pwr_stat.sram_retain, 1'b1);
    check("periph_clk_en", periph_clk_en, VERY_LOW_POWER_STOP_KEEP_MASK);
    flash_try(1'b0);
    wake_async = 8'h01;
    wait_mode(ST_WAKE);
    wake_async = 8'h00;
    wait_mode(ST_VERY_LOW_POWER_RUN);
    core_req.run_req = RUN_NORMAL;
    wait_mode(ST_RUN);
  endtask : t_stop

  initial begin
    repeat (16) step();
    t_reset();
    rst = 1'b0;
    step();
    t_security();
    t_run_modes();
    t_wait();
    t_stop();
    final_report();
  end
endmodule : lpm_ctrl_tb
`default_nettype wire
